/* rtl/flash_charge_controller.sv */
// flyback flash charger control, gate drive and AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module flash_charge_controller
    import flash_charge_pkg::*;
#(
    parameter int FILTER_COUNT = FILTER_CYCLES,
    parameter int CYCLE_W = 16
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // host control pins
    input wire logic CHARGE_REQUEST,
    input wire logic FLASH_PERMIT,
    input wire logic FLASH_TRIGGER,
    // analog comparators, asynchronous
    input wire logic FULL_COMPARATOR,
    input wire logic ZERO_COMPARATOR,
    input wire logic PEAK_COMPARATOR,
    input wire logic OCP_COMPARATOR,
    input wire logic THERMAL_COMPARATOR,
    // drive outputs
    output logic POWER_SWITCH_ON,
    output logic GATE_DRIVE_OUT,
    // open-drain done flag, low while enable high
    output logic CHARGE_DONE_N_O,
    output logic CHARGE_DONE_N_OE,
    // interrupt
    output logic IRQ,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // ==========================================================
    // declarations
    comp_if cmp ();

    charge_state_t state_r;
    charge_state_t state_nxt;
    logic [FILTER_W-1:0] filter_cnt_r;
    logic [CYCLE_W-1:0] cycle_cnt_r;
    logic req_q_r;
    logic internal_enable_latch_r;
    logic thermal_latch_r;
    logic overcurrent_latch_r;
    logic done_r;
    logic switch_r;
    logic gate_r;
    logic irq_r;
    logic [31:0] ctrl_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;

    logic req_rise;
    logic fault_any;
    logic filter_end;
    logic full_hit;
    logic ocp_hit;

    logic aw_full_r;
    logic w_full_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_go;
    logic wr_ctrl;
    logic wr_irq_stat;
    logic wr_irq_mask;

    // ==========================================================
    // address decode for both bus paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT)
            || (a == ADDR_IRQ_MASK) || (a == ADDR_CYCLES);
    endfunction : addr_ok

    // ==========================================================
    // comparator synchronisers
    comp_sync #(
        .N(COMP_COUNT)
    ) u_sync (
        .clk(CLOCK),
        .rst(RST),
        .raw({THERMAL_COMPARATOR, OCP_COMPARATOR, PEAK_COMPARATOR,
            ZERO_COMPARATOR, FULL_COMPARATOR}),
        .cmp(cmp.src)
    );

    // ==========================================================
    // charge sequence
    assign req_rise = CHARGE_REQUEST && !req_q_r;
    assign fault_any = thermal_latch_r || overcurrent_latch_r || cmp.thermal;
    assign filter_end = (filter_cnt_r == FILTER_W'(FILTER_COUNT - 1));
    assign full_hit = (state_r == ST_OFF) && cmp.full;
    assign ocp_hit = (state_r == ST_ON) && cmp.overcurrent_latch;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (req_rise && !fault_any) begin
                    state_nxt = ST_FILTER;
                end
            end
            ST_FILTER: begin
                if (filter_end) begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: begin
                if (cmp.overcurrent_latch) begin
                    state_nxt = ST_FAULT;
                end else if (cmp.peak) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_OFF: begin
                if (cmp.full) begin
                    state_nxt = ST_DONE;
                end else if (cmp.zero) begin
                    state_nxt = ST_ON;
                end
            end
            ST_DONE: state_nxt = ST_DONE;
            ST_FAULT: state_nxt = ST_FAULT;
            default: state_nxt = ST_IDLE;
        endcase
        if (cmp.thermal && state_nxt != ST_IDLE) begin
            state_nxt = ST_FAULT;
        end
        // a low request always ends the sequence
        if (!CHARGE_REQUEST) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_r <= ST_IDLE;
            req_q_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_q_r <= CHARGE_REQUEST;
        end
    end

    // filter counter; short request pulses never switch
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            filter_cnt_r <= '0;
        end else if (state_r == ST_FILTER) begin
            filter_cnt_r <= filter_cnt_r + FILTER_W'(1);
        end else begin
            filter_cnt_r <= '0;
        end
    end

    // switch-on count of this charge, saturating
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cycle_cnt_r <= '0;
        end else if (state_r == ST_IDLE && state_nxt == ST_FILTER) begin
            cycle_cnt_r <= '0;
        end else if (state_r != ST_ON && state_nxt == ST_ON && !(&cycle_cnt_r)) begin
            cycle_cnt_r <= cycle_cnt_r + CYCLE_W'(1);
        end
    end

    // ==========================================================
    // latches
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            internal_enable_latch_r <= 1'b0;
        end else if (state_r == ST_IDLE && state_nxt == ST_FILTER) begin
            internal_enable_latch_r <= 1'b1;
        end else if (!CHARGE_REQUEST || full_hit || state_nxt == ST_FAULT) begin
            internal_enable_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            thermal_latch_r <= 1'b0;
        end else if (cmp.thermal) begin
            thermal_latch_r <= 1'b1;
        end else if (!CHARGE_REQUEST) begin
            thermal_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            overcurrent_latch_r <= 1'b0;
        end else if (ocp_hit) begin
            overcurrent_latch_r <= 1'b1;
        end else if (!CHARGE_REQUEST && !cmp.peak) begin
            overcurrent_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            done_r <= 1'b0;
        end else if (!CHARGE_REQUEST) begin
            done_r <= 1'b0;
        end else if (full_hit && !cmp.thermal) begin
            done_r <= 1'b1;
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            switch_r <= 1'b0;
        end else begin
            switch_r <= (state_nxt == ST_ON) && !thermal_latch_r && !overcurrent_latch_r
                && !cmp.thermal;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= FLASH_PERMIT && FLASH_TRIGGER && ctrl_r[CTRL_FLASH_EN_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign POWER_SWITCH_ON = switch_r;
    assign GATE_DRIVE_OUT = gate_r;
    assign CHARGE_DONE_N_OE = done_r;
    assign CHARGE_DONE_N_O = 1'b0;
    assign IRQ = irq_r;

    // ==========================================================
    // irq status, write one to clear; set beats clear
    assign irq_ev[IRQ_DONE_BIT] = full_hit && CHARGE_REQUEST && !done_r;
    assign irq_ev[IRQ_THERMAL_BIT] = cmp.thermal && !thermal_latch_r;
    assign irq_ev[IRQ_OCP_BIT] = ocp_hit && !overcurrent_latch_r;
    assign irq_clr = wr_irq_stat && wstrb_r[0] ? wdata_r[IRQ_W-1:0] : '0;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_mask_r <= IRQ_MASK_RESET;
        end else if (wr_irq_mask && wstrb_r[0]) begin
            irq_mask_r <= wdata_r[IRQ_W-1:0];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ctrl && wstrb_r[0]) begin
            ctrl_r <= {31'h0, wdata_r[CTRL_FLASH_EN_BIT]};
        end
    end

    // ==========================================================
    // AXI4-Lite write path, address and data in either order
    assign wr_go = aw_full_r && w_full_r && !bvalid_r;
    assign wr_ctrl = wr_go && (awaddr_r == ADDR_CTRL);
    assign wr_irq_stat = wr_go && (awaddr_r == ADDR_IRQ_STAT);
    assign wr_irq_mask = wr_go && (awaddr_r == ADDR_IRQ_MASK);

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_full_r <= 1'b0;
            awready_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (S_AXI_AWVALID && awready_r) begin
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= S_AXI_AWADDR;
        end else if (bvalid_r && S_AXI_BREADY) begin
            aw_full_r <= 1'b0;
            awready_r <= 1'b1;
        end else if (!aw_full_r) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            w_full_r <= 1'b0;
            wready_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (S_AXI_WVALID && wready_r) begin
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
        end else if (bvalid_r && S_AXI_BREADY) begin
            w_full_r <= 1'b0;
            wready_r <= 1'b1;
        end else if (!w_full_r) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;

    // ==========================================================
    // AXI4-Lite read path, answer one cycle after address
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (S_AXI_ARVALID && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            case (S_AXI_ARADDR)
                ADDR_CTRL: rdata_r <= ctrl_r;
                ADDR_STATUS: begin
                    rdata_r <= 32'h0000_0000;
                    rdata_r[ST_ENABLE_BIT] <= internal_enable_latch_r;
                    rdata_r[ST_SWITCH_BIT] <= switch_r;
                    rdata_r[ST_DONE_BIT] <= done_r;
                    rdata_r[ST_THERMAL_BIT] <= thermal_latch_r;
                    rdata_r[ST_OCP_BIT] <= overcurrent_latch_r;
                    rdata_r[ST_GATE_BIT] <= gate_r;
                    rdata_r[ST_STATE_LSB +: 3] <= state_r;
                end
                ADDR_IRQ_STAT: rdata_r <= {{(32 - IRQ_W){1'b0}}, irq_stat_r};
                ADDR_IRQ_MASK: rdata_r <= {{(32 - IRQ_W){1'b0}}, irq_mask_r};
                ADDR_CYCLES: rdata_r <= {{(32 - CYCLE_W){1'b0}}, cycle_cnt_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end

    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;

endmodule : flash_charge_controller

/* rtl/flash_charge_pkg.sv */
// constants, types and register map of the flash charge controller
//
// Notes on behaviour
// - switch off when peak current exceeded
// - switch back on at kickback zero
// - full kickback ends charging, stops switching
// - charge done indicator pulls low
// - completion clears enable latch automatically
// - flash firing allowed after completion
// - over temperature latches charging off
// - thermal latch clears cool and request low
// - overcurrent during on time latches off
// - overcurrent latch clears on request low with peak comparator low
// - request latched, switching after filter delay
// - done released only by request low
// - gate off while flash permit low
package flash_charge_pkg;

    // ==========================================================
    // timing
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int FILTER_TIME_NS = 50000;
    localparam int FILTER_MAX_NS = 150000;
    // least time: round up to whole cycles
    localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int FILTER_MAX_CYCLES = FILTER_MAX_NS / CLOCK_PERIOD_NS;
    localparam int FILTER_W = 12;
    localparam int COMP_COUNT = 5;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CYCLES = 8'h10;

    localparam int CTRL_FLASH_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    localparam int ST_ENABLE_BIT = 0;
    localparam int ST_SWITCH_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_THERMAL_BIT = 3;
    localparam int ST_OCP_BIT = 4;
    localparam int ST_GATE_BIT = 5;
    localparam int ST_STATE_LSB = 8;

    localparam int IRQ_W = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_THERMAL_BIT = 1;
    localparam int IRQ_OCP_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // charge sequence, gray along idle-filter-on-off-done
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FILTER = 3'h1,
        ST_ON = 3'h3,
        ST_OFF = 3'h2,
        ST_DONE = 3'h6,
        ST_FAULT = 3'h7
    } charge_state_t;

endpackage : flash_charge_pkg

/* rtl/comp_if.sv */
// synchronised comparator levels passed to the charge control logic
interface comp_if;
    logic full;
    logic zero;
    logic peak;
    logic overcurrent_latch;
    logic thermal;

    modport src (output full, output zero, output peak, output overcurrent_latch, output thermal);
    modport dst (input full, input zero, input peak, input overcurrent_latch, input thermal);
endinterface : comp_if

/* rtl/comp_sync.sv */
// two-stage synchronisers for the analog comparator outputs
module comp_sync
    import flash_charge_pkg::*;
#(
    parameter int N = COMP_COUNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw comparator levels: thermal, ocp, peak, zero, full
    input wire logic [N-1:0] raw,
    // synchronised levels
    comp_if.src cmp
);
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;

    // ==========================================================
    // per-bit double flop
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= raw[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign cmp.full = sync_r[0];
    assign cmp.zero = sync_r[1];
    assign cmp.peak = sync_r[2];
    assign cmp.overcurrent_latch = sync_r[3];
    assign cmp.thermal = sync_r[4];

endmodule : comp_sync

/* bench/flyback_stage_model.sv */
// flyback power stage model driving the comparators
module flyback_stage_model #(
    parameter int ON_CYC = 4,
    parameter int OFF_CYC = 5,
    parameter int PULSES = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the controller
    input wire logic charge_request,
    input wire logic power_switch_on,
    // comparator levels
    output logic full,
    output logic zero,
    output logic peak
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============
    // stage state
    logic on_q;
    int t_r;
    int n_r;
    always_ff @(posedge clk) begin
        if (rst || !charge_request) begin
            {on_q, full, zero, peak} <= 4'h0;
            t_r <= 0;
            n_r <= 0;
        end else begin
            on_q <= power_switch_on;
            t_r <= (on_q != power_switch_on) ? 0 : t_r + 1;
            peak <= power_switch_on && t_r >= ON_CYC;
            if (power_switch_on && !on_q) begin
                n_r <= n_r + 1;
            end
            // kickback ends in zero until the last pulse, then full
            zero <= !power_switch_on && t_r >= OFF_CYC && n_r < PULSES;
            full <= full || (!power_switch_on && t_r >= OFF_CYC && n_r >= PULSES);
        end
    end
endmodule : flyback_stage_model

/* bench/flash_charge_checker.sv */
// assertion checker on the flash charge controller ports
module flash_charge_checker
    import flash_charge_pkg::*;
#(
    parameter int FILTER_COUNT = FILTER_CYCLES
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // host pins
    input wire logic CHARGE_REQUEST,
    input wire logic FLASH_PERMIT,
    input wire logic FLASH_TRIGGER,
    // comparators
    input wire logic FULL_COMPARATOR,
    input wire logic PEAK_COMPARATOR,
    input wire logic OCP_COMPARATOR,
    input wire logic THERMAL_COMPARATOR,
    // outputs
    input wire logic POWER_SWITCH_ON,
    input wire logic GATE_DRIVE_OUT,
    input wire logic CHARGE_DONE_N_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // ============
    // request age, for the start delay
    logic [15:0] age_r;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            age_r <= 16'h0;
        end else if (!CHARGE_REQUEST) begin
            age_r <= 16'h0;
        end else if (age_r != 16'hFFFF) begin
            age_r <= age_r + 16'h1;
        end
    end
    // ============
    // two sync stages plus one register
    sequence s_peak_held;
        (POWER_SWITCH_ON && PEAK_COMPARATOR)[*3];
    endsequence
    sequence s_full_held;
        (!POWER_SWITCH_ON && FULL_COMPARATOR && CHARGE_REQUEST)[*3];
    endsequence
    AST_PEAK_OFF: assert property (s_peak_held |=> !POWER_SWITCH_ON)
        else $error("switch on past peak");
    AST_FULL_DONE: assert property (s_full_held |=> CHARGE_DONE_N_OE)
        else $error("no done after full");
    AST_DONE_QUIET: assert property (CHARGE_DONE_N_OE |-> !POWER_SWITCH_ON)
        else $error("switch on while done");
    AST_DONE_HOLD: assert property (CHARGE_DONE_N_OE && CHARGE_REQUEST
        |=> CHARGE_DONE_N_OE)
        else $error("done lost with request");
    AST_DONE_RELEASE: assert property (!CHARGE_REQUEST
        |=> !CHARGE_DONE_N_OE && !POWER_SWITCH_ON)
        else $error("active without request");
    AST_GATE_PERMIT: assert property (GATE_DRIVE_OUT
        |-> $past(FLASH_PERMIT) && $past(FLASH_TRIGGER))
        else $error("gate without permit");
    AST_FILTER_MIN: assert property (POWER_SWITCH_ON |-> age_r > FILTER_COUNT)
        else $error("switch on too early");
    AST_FILTER_MAX: assert property (age_r == FILTER_COUNT + 3 |-> POWER_SWITCH_ON)
        else $error("switch on too late");
    AST_OCP_LATCH: assert property ((POWER_SWITCH_ON && OCP_COMPARATOR)[*3]
        |=> !POWER_SWITCH_ON[*6])
        else $error("overcurrent not latched");
    AST_THERMAL_OFF: assert property (THERMAL_COMPARATOR[*3] |=> !POWER_SWITCH_ON[*2])
        else $error("switch on while hot");
endmodule : flash_charge_checker

bind flash_charge_controller flash_charge_checker #(.FILTER_COUNT(FILTER_COUNT))
    flash_charge_checker_inst (.CLOCK, .RST, .CHARGE_REQUEST, .FLASH_PERMIT, .FLASH_TRIGGER,
    .FULL_COMPARATOR, .PEAK_COMPARATOR, .OCP_COMPARATOR, .THERMAL_COMPARATOR,
    .POWER_SWITCH_ON, .GATE_DRIVE_OUT, .CHARGE_DONE_N_OE);

/* bench/tb_flash_charge_controller.sv */
// self-checking bench for the flash charge controller
module tb_flash_charge_controller import flash_charge_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FC = 8;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
    logic CLOCK = 1'h0;
    logic RST, CHARGE_REQUEST, FLASH_PERMIT, FLASH_TRIGGER;
    logic FULL_COMPARATOR, ZERO_COMPARATOR, PEAK_COMPARATOR, OCP_COMPARATOR;
    logic THERMAL_COMPARATOR, POWER_SWITCH_ON, GATE_DRIVE_OUT, CHARGE_DONE_N_O;
    logic CHARGE_DONE_N_OE, IRQ, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic S_AXI_RREADY;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, lfsr_r;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    exp_t exp_q[$];
    exp_t mon_e;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    // pull-up on the open-drain done flag
    wire charge_done_n = CHARGE_DONE_N_OE ? CHARGE_DONE_N_O : 1'h1;

    flash_charge_controller #(.FILTER_COUNT(FC)) flash_charge_controller_inst (.*);
    flyback_stage_model flyback_stage_model_inst (
        .clk(CLOCK), .rst(RST), .charge_request(CHARGE_REQUEST),
        .power_switch_on(POWER_SWITCH_ON), .full(FULL_COMPARATOR),
        .zero(ZERO_COMPARATOR), .peak(PEAK_COMPARATOR));

    always #25 CLOCK = ~CLOCK;

    // ============
    // helpers
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step
    task automatic tick(input int k);
        repeat (k) @(posedge CLOCK);
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
        end while (S_AXI_BVALID !== 1'h1);
        check(32'(S_AXI_BRESP), 32'(r));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        exp_q.push_back('{d: d, m: m, r: r});
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
        end while (S_AXI_RVALID !== 1'h1);
    endtask : rd
    // one fault while switching, then recovery
    task automatic fault_run(input logic thermal);
        CHARGE_REQUEST <= 1'h1;
        repeat (200) if (POWER_SWITCH_ON !== 1'h1) @(posedge CLOCK);
        {THERMAL_COMPARATOR, OCP_COMPARATOR} <= {thermal, !thermal};
        tick(6);
        rd(ADDR_STATUS, thermal ? 32'h8 : 32'h10, 32'h1A, RESP_OKAY);
        OCP_COMPARATOR <= 1'h0;
        tick(10);
        check(32'(POWER_SWITCH_ON), 32'h0);
        CHARGE_REQUEST <= 1'h0;
        tick(6);
        rd(ADDR_STATUS, thermal ? 32'h8 : 32'h0, 32'h18, RESP_OKAY);
        THERMAL_COMPARATOR <= 1'h0;
        tick(6);
        rd(ADDR_STATUS, 32'h0, 32'h18, RESP_OKAY);
        check(32'(IRQ), 32'h1);
        wr(ADDR_IRQ_STAT, 32'h7, RESP_OKAY);
    endtask : fault_run

    // ============
    // read result monitor
    always @(posedge CLOCK) begin
        if (S_AXI_RVALID === 1'h1 && S_AXI_RREADY === 1'h1) begin
            mon_e = exp_q.pop_front();
            check(S_AXI_RDATA & mon_e.m, mon_e.d);
            check(32'(S_AXI_RRESP), 32'(mon_e.r));
        end
    end
    // bound on the whole run
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ============
    // main sequence
    initial begin
        {RST, S_AXI_BREADY, S_AXI_RREADY} = 3'h7;
        {CHARGE_REQUEST, FLASH_PERMIT, FLASH_TRIGGER, OCP_COMPARATOR} = 4'h0;
        {THERMAL_COMPARATOR, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = 4'h0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
        S_AXI_WSTRB = 4'hF;
        lfsr_r = 32'h2F6A;
        repeat (8) @(posedge CLOCK);
        RST <= 1'h0;
        tick(1);
        rd(ADDR_CTRL, CTRL_RESET, ALL, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, ALL, RESP_OKAY);
        rd(ADDR_IRQ_MASK, 32'h0, ALL, RESP_OKAY);
        rd(8'h14, 32'h0, ALL, RESP_SLVERR);
        wr(8'h14, ALL, RESP_SLVERR);
        $display("test reset done");
        // full charge with three switch pulses
        CHARGE_REQUEST <= 1'h1;
        n = 0;
        while (charge_done_n !== 1'h0 && n < 400) begin
            @(posedge CLOCK);
            n++;
        end
        check(32'(n < 400), 32'h1);
        rd(ADDR_STATUS, 32'h604, 32'h71F, RESP_OKAY);
        rd(ADDR_CYCLES, 32'h3, ALL, RESP_OKAY);
        check(32'(IRQ), 32'h0);
        rd(ADDR_IRQ_STAT, 32'h1, ALL, RESP_OKAY);
        wr(ADDR_IRQ_MASK, 32'h7, RESP_OKAY);
        tick(3);
        check(32'(IRQ), 32'h1);
        wr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
        tick(3);
        check(32'(IRQ), 32'h0);
        $display("test charge done");
        for (int c = 0; c < 2; c++) begin
            wr(ADDR_CTRL, 32'(c), RESP_OKAY);
            repeat (8) begin
                lfsr_r = lfsr_step(lfsr_r);
                FLASH_PERMIT <= lfsr_r[0];
                FLASH_TRIGGER <= lfsr_r[1];
                tick(2);
                check(32'(GATE_DRIVE_OUT), 32'(lfsr_r[0] & lfsr_r[1] & c[0]));
            end
        end
        check(32'(charge_done_n), 32'h0);
        CHARGE_REQUEST <= 1'h0;
        tick(2);
        check(32'(charge_done_n), 32'h1);
        $display("test flash done");
        fault_run(1'h0);
        $display("test overcurrent done");
        fault_run(1'h1);
        $display("test thermal done");
        tick(2);
        finish_test();
    end
endmodule : tb_flash_charge_controller
